// ===== hw/charger_ctrl_defs.svh
// timing counts and reset values for the charger detect and port power block
`ifndef CHARGER_CTRL_DEFS_SVH
`define CHARGER_CTRL_DEFS_SVH
`define CLK_HZ 25000000
`define RETRY_SHORT_S 1
`define RETRY_LONG_S 10
`define RETRY_SHORT_CYC (`CLK_HZ * `RETRY_SHORT_S)
`define RETRY_LONG_CYC (`CLK_HZ * `RETRY_LONG_S)
`define SHORT_ATTEMPTS 3
`define CHG_EN_RESET 8'h00
`define CT_NONE 3'h0
`define CT_DCP 3'h1
`define CT_CDP 3'h2
`define CT_SDP 3'h3
`define CT_LOW 3'h4
`define CT_HIGH 3'h5
`define CT_SUPER 3'h6
`endif

// ===== hw/charger_ctrl_pkg.sv
// types for the charger detect and port power block
package charger_ctrl_pkg;
  typedef enum logic [1:0] {det_idle, det_sense, det_done} det_state_type;
  typedef enum logic [1:0] {port_init, port_on, port_off} port_state_type;
endpackage

// ===== hw/charger_detect_port_power_ctrl.sv
// charger detection, per-port charging roles and dedicated-port over-current retry
// Behaviour
// - detection starts automatically on entering charger detect stage when enabled.
// - interrupt raised after classification; result readable from status.
// - shorted data lines report type 001.
// - DP reflected on DM reports 010, only with enhanced detect set.
// - pull-downs on both lines report type 011.
// - proprietary low, high, super high currents report 100, 101, 110.
// - detection may run on internal oscillator during wait refclock stage.
// - no upstream detection when upstream is HSIC.
// - charge enable bit 1 controls port 1, following bits following ports.
// - charging enabled port asserts its port power bit.
// - enabled port is CDP with host, DCP otherwise; else standard.
// - role between charging and standard never changes after configuration.
// - charging port power rises after init, drops on over-current.
// - ganged over-current drops all ports; individual only the affected one.
// - dedicated port off one second then on, three attempts.
// - afterwards retry forever with ten second off interval.
// - CDP and standard ports leave power and over-current to host.
// - each of four ports has its own port power output.
// - no charging on downstream HSIC ports.
`timescale 1ns/1ns
`include "charger_ctrl_defs.svh"
module charger_detect_port_power_ctrl #(
  parameter int PORTS = 4,
  parameter int SHORT_CYC = `RETRY_SHORT_CYC,
  parameter int LONG_CYC = `RETRY_LONG_CYC
) (
  input wire logic i_sys_clk,
  input wire logic i_sys_rst,
  input wire logic i_clk_en,
  input wire logic i_detect_enable,
  input wire logic i_enhanced_detect_enable,
  input wire logic i_charger_detect_stage,
  input wire logic i_wait_refclock_stage,
  input wire logic i_osc_detect_enable,
  input wire logic i_reference_clock_ok,
  input wire logic i_upstream_hsic,
  input wire logic i_sense_valid,
  input wire logic i_sense_short,
  input wire logic i_sense_reflect,
  input wire logic i_sense_pulldown,
  input wire logic [1:0] i_sense_prop,
  input wire logic i_status_ack,
  input wire logic i_charge_enable_we,
  input wire logic [7:0] i_charge_enable_wdata,
  input wire logic i_config_done,
  input wire logic i_init_done,
  input wire logic i_host_connected,
  input wire logic i_ganged,
  input wire logic [PORTS-1:0] i_downstream_hsic,
  input wire logic [PORTS-1:0] i_overcurrent_sense,
  output logic o_detect_active,
  output logic o_charger_irq,
  output logic [2:0] o_charger_type,
  output logic [7:0] o_charge_enable,
  output logic [PORTS-1:0] o_port_dcp,
  output logic [PORTS-1:0] o_port_cdp,
  output logic [PORTS-1:0] o_port_power_out
);

  ////////////////////////////////////////////////////////////////////////////
  // over-current pins are asynchronous: three flops, change accepted on agreement
  logic [PORTS-1:0] oc_s1, oc_s2, oc_s3, oc_q;
  logic [PORTS-1:0] next_oc_q;
  always_comb begin
    next_oc_q = oc_q;
    for (int k = 0; k < PORTS; k++) begin
      if (oc_s2[k] == oc_s3[k]) begin
        next_oc_q[k] = oc_s3[k];
      end
    end
  end
  always_ff @(posedge i_sys_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      oc_s1 <= '0;
      oc_s2 <= '0;
      oc_s3 <= '0;
      oc_q <= '0;
    end else if (i_clk_en) begin
      oc_s1 <= i_overcurrent_sense;
      oc_s2 <= oc_s1;
      oc_s3 <= oc_s2;
      oc_q <= next_oc_q;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // upstream detection
  charger_ctrl_pkg::det_state_type det_state, next_det_state;
  logic stage_q, next_stage_q;
  logic [2:0] ctype, next_ctype;
  logic irq, next_irq;
  logic may_run;
  logic [2:0] classified;

  // without a reference clock, only the oscillator path may start a run
  assign may_run = i_detect_enable && !i_upstream_hsic &&
    (i_reference_clock_ok || (i_wait_refclock_stage && i_osc_detect_enable));

  always_comb begin
    classified = `CT_NONE;
    if (i_sense_short) begin
      classified = `CT_DCP;
    end else if (i_sense_reflect && i_enhanced_detect_enable) begin
      classified = `CT_CDP;
    end else if (i_sense_pulldown) begin
      classified = `CT_SDP;
    end else if (i_sense_prop != 2'h0) begin
      classified = 3'(`CT_LOW + {1'b0, i_sense_prop} - 3'h1);
    end
  end

  always_comb begin
    next_det_state = det_state;
    next_stage_q = i_charger_detect_stage;
    next_ctype = ctype;
    next_irq = irq;
    if (i_status_ack) begin
      next_irq = 1'b0;
    end
    unique case (det_state)
      charger_ctrl_pkg::det_idle: begin
        if (i_charger_detect_stage && !stage_q && may_run) begin
          next_det_state = charger_ctrl_pkg::det_sense;
        end
      end
      charger_ctrl_pkg::det_sense: begin
        if (i_sense_valid) begin
          next_ctype = classified;
          next_irq = 1'b1;
          next_det_state = charger_ctrl_pkg::det_done;
        end
      end
      charger_ctrl_pkg::det_done: begin
        next_det_state = charger_ctrl_pkg::det_idle;
      end
    endcase
  end

  always_ff @(posedge i_sys_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      det_state <= charger_ctrl_pkg::det_idle;
      stage_q <= 1'b0;
      ctype <= `CT_NONE;
      irq <= 1'b0;
    end else if (i_clk_en) begin
      det_state <= next_det_state;
      stage_q <= next_stage_q;
      ctype <= next_ctype;
      irq <= next_irq;
    end
  end

  assign o_detect_active = (det_state == charger_ctrl_pkg::det_sense);
  assign o_charger_irq = irq;
  assign o_charger_type = ctype;

  ////////////////////////////////////////////////////////////////////////////
  // charging enable register; roles freeze once configuration is done
  logic [7:0] chg_en, next_chg_en;
  always_comb begin
    next_chg_en = chg_en;
    if (i_charge_enable_we && !i_config_done) begin
      next_chg_en = i_charge_enable_wdata;
    end
  end
  always_ff @(posedge i_sys_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      chg_en <= `CHG_EN_RESET;
    end else if (i_clk_en) begin
      chg_en <= next_chg_en;
    end
  end
  assign o_charge_enable = chg_en;

  ////////////////////////////////////////////////////////////////////////////
  // per-port roles and power
  logic [PORTS-1:0] charging, dcp, power_on, oc_trip;
  logic any_trip;
  assign any_trip = |oc_trip;

  genvar p;
  generate
    for (p = 0; p < PORTS; p++) begin : g_port
      charger_ctrl_pkg::port_state_type st, next_st;
      logic [31:0] cnt, next_cnt;
      logic [1:0] tries, next_tries;

      assign charging[p] = chg_en[p+1] && !i_downstream_hsic[p];
      assign dcp[p] = charging[p] && !i_host_connected;
      assign oc_trip[p] = charging[p] && oc_q[p] && (st == charger_ctrl_pkg::port_on);

      always_comb begin
        next_st = st;
        next_cnt = cnt;
        next_tries = tries;
        unique case (st)
          charger_ctrl_pkg::port_init: begin
            if (i_init_done && charging[p]) begin
              next_st = charger_ctrl_pkg::port_on;
            end
          end
          charger_ctrl_pkg::port_on: begin
            // a quiet port after re-enable is healthy again
            if (!oc_q[p]) begin
              next_tries = 2'h0;
            end
            if (oc_trip[p] || (i_ganged && any_trip)) begin
              next_st = charger_ctrl_pkg::port_off;
              next_cnt = '0;
            end
          end
          charger_ctrl_pkg::port_off: begin
            next_cnt = cnt + 32'h0000_0001;
            if (!dcp[p]) begin
              // host owns recovery on CDP/SDP; hold off until it clears
              if (!oc_q[p] && !(i_ganged && |oc_q)) begin
                next_st = charger_ctrl_pkg::port_on;
              end
            end else if (tries < 2'(`SHORT_ATTEMPTS)) begin
              if (cnt >= 32'(SHORT_CYC - 1)) begin
                next_st = charger_ctrl_pkg::port_on;
                next_tries = tries + 2'h1;
              end
            end else if (cnt >= 32'(LONG_CYC - 1)) begin
              next_st = charger_ctrl_pkg::port_on;
            end
          end
        endcase
      end

      always_ff @(posedge i_sys_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
          st <= charger_ctrl_pkg::port_init;
          cnt <= '0;
          tries <= 2'h0;
        end else if (i_clk_en) begin
          st <= next_st;
          cnt <= next_cnt;
          tries <= next_tries;
        end
      end

      assign power_on[p] = (st == charger_ctrl_pkg::port_on) && charging[p];

      long_wait_a: assert property (@(posedge i_sys_clk) disable iff (i_sys_rst)
        (st == charger_ctrl_pkg::port_off && dcp[p] && tries == 2'h3 && cnt < 32'(LONG_CYC - 1))
        |=> (st == charger_ctrl_pkg::port_off || !i_clk_en || !dcp[p]))
        else $error("long retry ended early");
      short_wait_a: assert property (@(posedge i_sys_clk) disable iff (i_sys_rst)
        (st == charger_ctrl_pkg::port_off && dcp[p] && tries < 2'h3 && cnt == 32'(SHORT_CYC - 1) && i_clk_en)
        |=> st == charger_ctrl_pkg::port_on)
        else $error("short retry did not re-enable");
    end
  endgenerate

  assign o_port_dcp = dcp;
  assign o_port_cdp = charging & ~dcp;
  assign o_port_power_out = power_on;

  ////////////////////////////////////////////////////////////////////////////
  // checks
  type_map_a: assert property (@(posedge i_sys_clk) disable iff (i_sys_rst)
    (det_state == charger_ctrl_pkg::det_sense && i_sense_valid && i_sense_short && i_clk_en)
    |=> o_charger_type == 3'h1)
    else $error("shorted lines not reported as dcp");
  cdp_gate_a: assert property (@(posedge i_sys_clk) disable iff (i_sys_rst)
    (det_state == charger_ctrl_pkg::det_sense && i_sense_valid && !i_sense_short && i_clk_en
     && !i_enhanced_detect_enable) |=> o_charger_type != 3'h2)
    else $error("cdp reported without enhanced detect");
  irq_raise_a: assert property (@(posedge i_sys_clk) disable iff (i_sys_rst)
    (det_state == charger_ctrl_pkg::det_sense && i_sense_valid && i_clk_en) |=> o_charger_irq)
    else $error("interrupt missing after classification");
  det_start_a: assert property (@(posedge i_sys_clk) disable iff (i_sys_rst)
    (det_state == charger_ctrl_pkg::det_idle && i_charger_detect_stage && !stage_q && may_run && i_clk_en)
    |=> o_detect_active)
    else $error("detection did not start");
  hsic_block_a: assert property (@(posedge i_sys_clk) disable iff (i_sys_rst)
    (det_state == charger_ctrl_pkg::det_idle && i_upstream_hsic) |=> !o_detect_active)
    else $error("detection ran on hsic upstream");
  role_freeze_a: assert property (@(posedge i_sys_clk) disable iff (i_sys_rst)
    i_config_done |=> $stable(o_charge_enable))
    else $error("role changed after configuration");
  std_off_a: assert property (@(posedge i_sys_clk) disable iff (i_sys_rst)
    (o_port_power_out & ~(o_charge_enable[PORTS:1] & ~i_downstream_hsic)) == '0)
    else $error("standard port powered");
  trip_off_a: assert property (@(posedge i_sys_clk) disable iff (i_sys_rst)
    (any_trip && i_clk_en) |=> (o_port_power_out & $past(oc_trip)) == '0)
    else $error("power stayed on after over-current");
  gang_off_a: assert property (@(posedge i_sys_clk) disable iff (i_sys_rst)
    (any_trip && i_ganged && i_clk_en) |=> o_port_power_out == '0)
    else $error("ganged ports not all dropped");
  detect_c: cover property (@(posedge i_sys_clk) o_detect_active ##[1:20] o_charger_irq);
  retry_c: cover property (@(posedge i_sys_clk) any_trip ##1 o_port_power_out == '0);
  sdp_c: cover property (@(posedge i_sys_clk) o_charger_type == 3'h3);

endmodule // charger_detect_port_power_ctrl

// ===== sim/charger_far_side.sv
// behavioural model of the charger front end seen by the detection logic
`timescale 1ns/1ns
module charger_far_side #(
  parameter int DLY = 2
) (
  input wire logic i_clk,
  input wire logic i_active,
  input wire logic [2:0] i_profile,
  output logic o_valid,
  output logic o_short,
  output logic o_reflect,
  output logic o_pulldown,
  output logic [1:0] o_prop
);
  logic [3:0] cnt = 4'h0;
  logic junk = 1'b0;
  // profile settles a few cycles after sensing starts, then is shown once
  // outside a run the lines only toggle and valid stays low; software keeps to its own stages
  always @(posedge i_clk) begin
    junk <= ~junk;
    cnt <= i_active ? cnt + 4'h1 : 4'h0;
    o_valid <= i_active && cnt == 4'(DLY);
  end
  // outside the valid cycle the lines carry a toggling pattern, not stale data
  always_comb begin
    o_short = o_valid ? i_profile == 3'h1 : junk;
    o_reflect = o_valid ? i_profile == 3'h2 : ~junk;
    o_pulldown = o_valid ? i_profile == 3'h3 : junk;
    o_prop = o_valid ? (i_profile > 3'h3 ? 2'(i_profile - 3'h3) : 2'h0) : {junk, ~junk};
  end
endmodule // charger_far_side

// ===== sim/testbench.sv
// self-checking bench for the charger detect and port power block
`timescale 1ns/1ns
module testbench;
  localparam int S = 20;
  localparam int L = 50;
  logic clk = 0, rst = 1, enh = 1, stage = 0, wstage = 0, osc = 0, ref_ok = 1, up_hsic = 0;
  logic ack = 0, we = 0, cfg = 0, init = 0, host = 0, ganged = 0, en = 1, det_en = 1;
  logic [7:0] wdata = 8'h00;
  logic [3:0] oc = 4'h0, ds_hsic = 4'h0;
  logic [2:0] prof = 3'h0;
  logic valid, sh, rf, pd, active, irq;
  logic [1:0] pr;
  logic [2:0] ctype;
  logic [7:0] chg;
  logic [3:0] dcp, cdp, pwr;
  int err_total = 0, checks = 0, cyc = 0, n;
  ////////////////////////////////////////////////////////////////
  charger_detect_port_power_ctrl #(.PORTS(4), .SHORT_CYC(S), .LONG_CYC(L)) uut (
    .i_sys_clk(clk), .i_sys_rst(rst), .i_clk_en(en), .i_detect_enable(det_en),
    .i_enhanced_detect_enable(enh), .i_charger_detect_stage(stage), .i_wait_refclock_stage(wstage),
    .i_osc_detect_enable(osc), .i_reference_clock_ok(ref_ok), .i_upstream_hsic(up_hsic),
    .i_sense_valid(valid), .i_sense_short(sh), .i_sense_reflect(rf), .i_sense_pulldown(pd),
    .i_sense_prop(pr), .i_status_ack(ack), .i_charge_enable_we(we), .i_charge_enable_wdata(wdata),
    .i_config_done(cfg), .i_init_done(init), .i_host_connected(host), .i_ganged(ganged),
    .i_downstream_hsic(ds_hsic), .i_overcurrent_sense(oc), .o_detect_active(active),
    .o_charger_irq(irq), .o_charger_type(ctype), .o_charge_enable(chg), .o_port_dcp(dcp),
    .o_port_cdp(cdp), .o_port_power_out(pwr));
  charger_far_side #(.DLY(2)) far (.i_clk(clk), .i_active(active), .i_profile(prof), .o_valid(valid),
    .o_short(sh), .o_reflect(rf), .o_pulldown(pd), .o_prop(pr));
  initial forever #20 clk = ~clk;
  always @(posedge clk) begin
    cyc++;
    if (cyc == 5000) begin
      err_total++;
      wrap_up();
    end
  end
  ////////////////////////////////////////////////////////////////
  task chk(input logic [7:0] got, input logic [7:0] exp, input string m);
    checks++;
    if (got !== exp) begin
      err_total++;
      $display("BAD %0t %s got %h exp %h", $time, m, got, exp);
    end
  endtask
  task rng(input int k, input int e, input string m);
    checks++;
    if (k < e - 1 || k > e + 1) begin
      err_total++;
      $display("BAD %0t %s off for %0d cycles, wanted %0d", $time, m, k, e);
    end
  endtask
  task detect(input logic [2:0] p, input logic [2:0] e);
    prof = p;
    stage = 1;
    @(negedge clk);
    chk(active, 1, "run started");
    n = 0;
    while (irq !== 1'b1 && n < 20) begin
      @(posedge clk);
      #1;
      n++;
    end
    chk(irq, 1, "irq after result");
    chk(ctype, e, "charger type");
    @(negedge clk);
    ack = 1;
    stage = 0;
    @(negedge clk);
    ack = 0;
    chk(irq, 0, "irq after ack");
  endtask
  // fall-to-rise time of port 0 power, counted at falling edges
  task off_len(output int k);
    k = 0;
    n = 0;
    while (pwr[0] !== 1'b0 && n < 20) begin
      @(negedge clk);
      n++;
    end
    while (pwr[0] === 1'b0 && k < 200) begin
      @(negedge clk);
      k++;
    end
  endtask
  // drop the fault while the port is off so the re-enable sees it clean
  task release_oc;
    n = 0;
    while (pwr[0] !== 1'b0 && n < 20) begin
      @(negedge clk);
      n++;
    end
    oc = 4'h0;
    repeat (L + 10) @(negedge clk);
  endtask
  // a start that must be refused: no run and no result
  task refused(input string m);
    stage = 1;
    @(negedge clk);
    chk(active, 0, m);
    repeat (5) @(negedge clk);
    chk(irq, 0, m);
    stage = 0;
    @(negedge clk);
  endtask
  ////////////////////////////////////////////////////////////////
  task t_detect;
    for (int p = 1; p < 7; p++) detect(3'(p), 3'(p));
    enh = 0;
    detect(3'h2, 3'h0);
    enh = 1;
    ref_ok = 0;
    wstage = 1;
    osc = 1;
    detect(3'h3, 3'h3);
    wstage = 0;
    osc = 0;
    refused("run with no clock path");
    ref_ok = 1;
    up_hsic = 1;
    refused("run on hsic upstream");
    up_hsic = 0;
    det_en = 0;
    refused("run while disabled");
    det_en = 1;
    // a frozen block must not see the stage edge until it runs again
    en = 0;
    stage = 1;
    repeat (3) @(negedge clk);
    chk(active, 0, "run while frozen");
    en = 1;
    detect(3'h1, 3'h1);
    $display("detect test done");
  endtask
  task t_ports;
    we = 1;
    wdata = 8'h06;
    @(negedge clk);
    we = 0;
    chk(chg, 8'h06, "enable write");
    chk(pwr, 4'h0, "power before init");
    cfg = 1;
    init = 1;
    repeat (2) @(negedge clk);
    chk(pwr, 4'h3, "power after init");
    chk(dcp, 4'h3, "dedicated roles");
    we = 1;
    wdata = 8'h1E;
    @(negedge clk);
    we = 0;
    chk(chg, 8'h06, "late write");
    host = 1;
    @(negedge clk);
    chk(cdp, 4'h3, "downstream roles");
    host = 0;
    ds_hsic = 4'h2;
    @(negedge clk);
    chk(pwr, 4'h1, "hsic port powered");
    ds_hsic = 4'h0;
    @(negedge clk);
    $display("port test done");
  endtask
  task t_retry;
    oc[0] = 1;
    repeat (3) begin
      off_len(n);
      rng(n, S, "short retry");
      chk(pwr[1], 1, "neighbour port");
    end
    repeat (2) begin
      off_len(n);
      rng(n, L, "long retry");
    end
    release_oc();
    chk(pwr, 4'h3, "power after fault");
    oc[0] = 1;
    off_len(n);
    rng(n, S, "retry count cleared");
    release_oc();
    $display("retry test done");
  endtask
  task t_gang;
    ganged = 1;
    oc[1] = 1;
    repeat (8) @(negedge clk);
    chk(pwr, 4'h0, "ganged fault");
    oc = 4'h0;
    repeat (L + 10) @(negedge clk);
    chk(pwr, 4'h3, "ganged recovery");
    $display("ganged test done");
  endtask
  // a late reset clears everything; frozen config keeps all ports standard
  task t_reset;
    rst = 1;
    @(negedge clk);
    chk(chg, 8'h00, "enable in reset");
    chk(pwr, 4'h0, "power in reset");
    chk({irq, ctype}, 8'h00, "result in reset");
    rst = 0;
    repeat (2) @(negedge clk);
    chk(pwr, 4'h0, "power after late reset");
    $display("reset test done");
  endtask
  task wrap_up;
    $display("checks %0d mismatches %0d", checks, err_total);
    if (err_total == 0 && checks > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  initial begin
    repeat (10) @(negedge clk);
    rst = 0;
    @(negedge clk);
    t_detect();
    t_ports();
    t_retry();
    t_gang();
    t_reset();
    wrap_up();
  end
endmodule // testbench
